// ==== hdl/tdm_network_pkg.sv ====
// Constants shared by the TDM network-mode serial port.
// Assumes a single 100 MHz system clock; pins are sampled by the port itself.
package tdm_network_pkg;

  // ----------------------------------------------------------------
  // Word length and data width
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 24;
  localparam logic [1:0] WL_SEL_8 = 2'h0;
  localparam logic [1:0] WL_SEL_12 = 2'h1;
  localparam logic [1:0] WL_SEL_16 = 2'h2;
  localparam logic [4:0] WL_BITS_8 = 5'h08;
  localparam logic [4:0] WL_BITS_12 = 5'h0c;
  localparam logic [4:0] WL_BITS_16 = 5'h10;
  localparam logic [4:0] WL_BITS_24 = 5'h18;

  // ----------------------------------------------------------------
  // Bit clock divider
  // ----------------------------------------------------------------
  localparam int unsigned DIV_W = 12;
  localparam int unsigned RANGE_SHIFT = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DIV_W-1:0] DIV_RST = 12'h000;
  localparam logic [4:0] CNT_RST = 5'h00;
  localparam logic [DATA_W-1:0] WORD_RST = 24'h00_0000;
  localparam logic [1:0] FLAG_RST = 2'h0;
  localparam logic [1:0] SYNC_RST = 2'h0;
  localparam logic HOLD_EMPTY_RST = 1'b1;

  // Word length in bits from the two-bit select
  function automatic logic [4:0] wl_bits(input logic [1:0] sel);
    case (sel)
      WL_SEL_8: wl_bits = WL_BITS_8;
      WL_SEL_12: wl_bits = WL_BITS_12;
      WL_SEL_16: wl_bits = WL_BITS_16;
      default: wl_bits = WL_BITS_24;
    endcase
  endfunction : wl_bits

endpackage : tdm_network_pkg

// ==== hdl/tdm_network_serial_port.sv ====
// TDM network-mode synchronous serial port: bit clock, frame sync,
// slot timing, transmit/receive holding words and their status flags.
// Assumes software drives the strobes from clk_in logic; link pins are async.

module tdm_network_serial_port
  import tdm_network_pkg::*;
(
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Async reset, active high
  input wire logic ce_in, // Clock enable
  input wire logic network_select_in, // Network mode on
  input wire logic link_master_in, // Port makes bit clock and frame sync
  input wire logic [1:0] word_length_field_in, // Word length select
  input wire logic [4:0] slots_per_frame_field_in, // Slots minus one
  input wire logic prescaler_range_bit_in, // Extra divide by eight
  input wire logic [7:0] prescale_modulus_field_in, // Divider modulus
  input wire logic gated_clock_select_in, // Bit clock only while active
  input wire logic shared_clock_select_in, // Common tx/rx timing
  input wire logic [1:0] frame_pulse_length_bits_in, // Frame pulse length
  input wire logic xmit_on_bit_in, // Transmitter enable
  input wire logic rcv_on_bit_in, // Receiver enable
  input wire logic xmit_irq_on_in, // Transmit request enable
  input wire logic rcv_irq_on_in, // Receive request enable
  input wire logic [1:0] output_flag_bits_in, // Flags for the pins
  input wire logic xmit_hold_wr_in, // Write transmit holding word
  input wire logic [DATA_W-1:0] xmit_hold_data_in, // Word to send
  input wire logic slot_skip_wr_in, // Skip next slot
  input wire logic rcv_hold_rd_in, // Read receive holding word
  input wire logic xmit_underrun_clr_in, // Clear underrun flag
  input wire logic rcv_overrun_clr_in, // Clear overrun flag
  input wire logic serial_clk_in, // Bit clock from the link
  input wire logic frame_sync_in, // Frame sync from the link
  input wire logic serial_in_pin_in, // Receive data pin
  output logic serial_clk_out, // Bit clock to the link
  output logic frame_sync_out, // Frame sync to the link
  output logic serial_out_pin_out, // Transmit data pin
  output logic serial_out_oe_out, // Transmit pin drive enable
  output logic [1:0] output_flag_out, // Slot flag pins
  output logic xmit_hold_empty_out, // Holding word taken
  output logic xmit_underrun_flag_out, // Underrun sticky flag
  output logic rcv_hold_full_out, // Receive word ready
  output logic rcv_overrun_flag_out, // Overrun sticky flag
  output logic [DATA_W-1:0] rcv_hold_out, // Received word
  output logic xmit_frame_slot_out, // Loaded word is in slot 0
  output logic rcv_frame_slot_out, // Held word came from slot 0
  output logic xmit_irq_out, // Transmit service request
  output logic rcv_irq_out // Receive service request
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sclk_sync_r;
  logic [1:0] fsync_sync_r;
  logic [1:0] sdata_sync_r;
  logic sclk_prev_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_sync_r <= SYNC_RST;
      fsync_sync_r <= SYNC_RST;
      sdata_sync_r <= SYNC_RST;
      sclk_prev_r <= 1'b0;
    end else if (ce_in) begin
      sclk_sync_r <= {sclk_sync_r[0], serial_clk_in};
      fsync_sync_r <= {fsync_sync_r[0], frame_sync_in};
      sdata_sync_r <= {sdata_sync_r[0], serial_in_pin_in};
      sclk_prev_r <= sclk_sync_r[1];
    end
  end

  // ----------------------------------------------------------------
  // Bit clock divider
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_cnt_r;
  logic [DIV_W-1:0] div_reload;
  logic [8:0] modulus_plus1;
  logic clk_r;
  logic div_tick;
  assign modulus_plus1 = {1'b0, prescale_modulus_field_in} + 9'h001;
  assign div_reload = prescaler_range_bit_in ? {modulus_plus1, 3'h0} : {3'h0, modulus_plus1};
  assign div_tick = (div_cnt_r == DIV_RST);
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_cnt_r <= DIV_RST;
      clk_r <= 1'b0;
    end else if (ce_in) begin
      if (div_tick) begin
        div_cnt_r <= div_reload - 12'h001;
        clk_r <= ~clk_r;
      end else begin
        div_cnt_r <= div_cnt_r - 12'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bit edges and slot timing
  // ----------------------------------------------------------------
  logic rise_e;
  logic fall_e;
  logic [4:0] wl;
  logic [4:0] bit_cnt_r;
  logic [4:0] slot_cnt_r;
  logic run_r;
  logic fs_prev_r;
  logic end_slot;
  logic frame_start;
  logic slot_bound;
  assign rise_e = link_master_in ? (div_tick & ~clk_r) : (sclk_sync_r[1] & ~sclk_prev_r);
  assign fall_e = link_master_in ? (div_tick & clk_r) : (~sclk_sync_r[1] & sclk_prev_r);
  assign wl = wl_bits(word_length_field_in);
  assign end_slot = (bit_cnt_r == wl - 5'h01);
  // generated on wrap, detected on sync edge
  assign frame_start = link_master_in ?
    (~run_r | (end_slot & (slot_cnt_r == slots_per_frame_field_in))) :
    (fsync_sync_r[1] & ~fs_prev_r);
  assign slot_bound = rise_e & network_select_in & (frame_start | (run_r & end_slot));
  // slot count wraps at field value
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bit_cnt_r <= CNT_RST;
      slot_cnt_r <= CNT_RST;
      run_r <= 1'b0;
      fs_prev_r <= 1'b0;
    end else if (ce_in) begin
      if (!network_select_in) begin
        bit_cnt_r <= CNT_RST;
        slot_cnt_r <= CNT_RST;
        run_r <= 1'b0;
      end else if (rise_e) begin
        fs_prev_r <= fsync_sync_r[1];
        if (frame_start) begin
          bit_cnt_r <= CNT_RST;
          slot_cnt_r <= CNT_RST;
          run_r <= 1'b1;
        end else if (run_r && end_slot) begin
          bit_cnt_r <= CNT_RST;
          slot_cnt_r <= (slot_cnt_r == slots_per_frame_field_in) ? CNT_RST : slot_cnt_r + 5'h01;
        end else if (run_r) begin
          bit_cnt_r <= bit_cnt_r + 5'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock, frame sync and flag pins
  // ----------------------------------------------------------------
  logic tx_active_r;
  logic rx_active_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      serial_clk_out <= 1'b0;
      frame_sync_out <= 1'b0;
      output_flag_out <= FLAG_RST;
    end else if (ce_in) begin
      // gated clock only runs while a direction is active
      serial_clk_out <= link_master_in & clk_r & (~gated_clock_select_in | tx_active_r | rx_active_r);
      if (!link_master_in || !network_select_in) begin
        frame_sync_out <= 1'b0;
      end else if (rise_e) begin
        if (frame_start) begin
          frame_sync_out <= 1'b1;
        end else if (frame_pulse_length_bits_in != 2'h0 || end_slot) begin
          frame_sync_out <= 1'b0;
        end
      end
      if (slot_bound) begin
        output_flag_out <= output_flag_bits_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] xmit_hold_r;
  logic [DATA_W-1:0] last_word_r;
  logic [DATA_W-1:0] tx_shift_r;
  logic [DATA_W-1:0] tx_word;
  logic skip_pending_r;
  logic tx_off_seen_r;
  logic tx_active_nxt;
  logic [4:0] align_sh;
  assign tx_active_nxt = frame_start ? xmit_on_bit_in : (tx_active_r & ~tx_off_seen_r & xmit_on_bit_in);
  assign tx_word = xmit_hold_empty_out ? last_word_r : xmit_hold_r;
  assign align_sh = WL_BITS_24 - wl;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_active_r <= 1'b0;
      tx_off_seen_r <= 1'b0;
    end else if (ce_in) begin
      if (slot_bound) begin
        tx_active_r <= tx_active_nxt;
        tx_off_seen_r <= 1'b0;
      end else if (!xmit_on_bit_in && tx_active_r) begin
        tx_off_seen_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tx_shift_r <= WORD_RST;
      last_word_r <= WORD_RST;
      serial_out_pin_out <= 1'b0;
      serial_out_oe_out <= 1'b0;
      xmit_frame_slot_out <= 1'b0;
    end else if (ce_in) begin
      if (slot_bound) begin
        xmit_frame_slot_out <= frame_start;
        if (tx_active_nxt && !skip_pending_r) begin
          tx_shift_r <= (tx_word << align_sh) << 1;
          serial_out_pin_out <= tx_word[wl - 5'h01];
          serial_out_oe_out <= 1'b1;
          last_word_r <= tx_word;
        end else begin
          // skipped or idle slot stays undriven
          serial_out_oe_out <= 1'b0;
        end
      end else if (rise_e && run_r) begin
        serial_out_pin_out <= tx_shift_r[DATA_W-1];
        tx_shift_r <= tx_shift_r << 1;
      end
      if (!network_select_in) begin
        serial_out_oe_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      xmit_hold_r <= WORD_RST;
      xmit_hold_empty_out <= HOLD_EMPTY_RST;
      skip_pending_r <= 1'b0;
      xmit_underrun_flag_out <= 1'b0;
    end else if (ce_in) begin
      // a write beats the same-cycle load
      if (xmit_hold_wr_in || slot_skip_wr_in) begin
        xmit_hold_empty_out <= 1'b0;
        skip_pending_r <= slot_skip_wr_in & ~xmit_hold_wr_in;
      end else if (slot_bound && tx_active_nxt) begin
        xmit_hold_empty_out <= 1'b1;
        skip_pending_r <= 1'b0;
      end
      if (xmit_hold_wr_in) begin
        xmit_hold_r <= xmit_hold_data_in;
      end
      if (slot_bound && tx_active_nxt && xmit_hold_empty_out && !skip_pending_r) begin
        xmit_underrun_flag_out <= 1'b1;
      end else if (xmit_underrun_clr_in) begin
        xmit_underrun_flag_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rx_shift_r;
  logic [DATA_W-1:0] rx_mask;
  logic rx_off_seen_r;
  logic rx_take;
  // Shared timing only: tx and rx always use one clock and sync
  assign rx_mask = 24'hFF_FFFF >> align_sh;
  // every completed slot of an active receiver
  assign rx_take = slot_bound & run_r & rx_active_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_active_r <= 1'b0;
      rx_off_seen_r <= 1'b0;
      rx_shift_r <= WORD_RST;
    end else if (ce_in) begin
      // toggled enable waits for frame start
      if (slot_bound) begin
        rx_active_r <= frame_start ? rcv_on_bit_in : (rx_active_r & ~rx_off_seen_r & rcv_on_bit_in);
        rx_off_seen_r <= 1'b0;
      end else if (!rcv_on_bit_in && rx_active_r) begin
        rx_off_seen_r <= 1'b1;
      end
      if (fall_e && run_r) begin
        rx_shift_r <= {rx_shift_r[DATA_W-2:0], sdata_sync_r[1]};
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rcv_hold_out <= WORD_RST;
      rcv_hold_full_out <= 1'b0;
      rcv_overrun_flag_out <= 1'b0;
      rcv_frame_slot_out <= 1'b0;
    end else if (ce_in) begin
      // unread full word drops the new one; a same-cycle read frees it
      if (rx_take && (!rcv_hold_full_out || rcv_hold_rd_in)) begin
        rcv_hold_out <= rx_shift_r & rx_mask;
        rcv_frame_slot_out <= (slot_cnt_r == CNT_RST);
      end
      // full on transfer, set beats read
      if (rx_take) begin
        rcv_hold_full_out <= 1'b1;
      end else if (rcv_hold_rd_in) begin
        rcv_hold_full_out <= 1'b0;
      end
      if (rx_take && rcv_hold_full_out && !rcv_hold_rd_in) begin
        rcv_overrun_flag_out <= 1'b1;
      end else if (rcv_overrun_clr_in) begin
        rcv_overrun_flag_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Service requests
  // ----------------------------------------------------------------
  // Level requests lag the flags by one cycle to stay registered
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      xmit_irq_out <= 1'b0;
      rcv_irq_out <= 1'b0;
    end else if (ce_in) begin
      xmit_irq_out <= xmit_irq_on_in & xmit_hold_empty_out & tx_active_r;
      rcv_irq_out <= rcv_irq_on_in & rcv_hold_full_out;
    end
  end

endmodule : tdm_network_serial_port

// ==== verif/tdm_network_chk.sv ====
// Concurrent checks on the TDM serial port's status and link outputs.
// Assumes the checker is bound to the port and sees its ports only.
module tdm_network_chk
  import tdm_network_pkg::*;
(
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Async reset
  input wire logic ce_in, // Clock enable
  input wire logic network_select_in, // Network mode
  input wire logic link_master_in, // Master mode
  input wire logic prescaler_range_bit_in, // Extra divide
  input wire logic [7:0] prescale_modulus_field_in, // Modulus
  input wire logic gated_clock_select_in, // Gated clock
  input wire logic xmit_hold_wr_in, // Data write
  input wire logic slot_skip_wr_in, // Skip write
  input wire logic xmit_irq_on_in, // Tx request on
  input wire logic rcv_irq_on_in, // Rx request on
  input wire logic xmit_underrun_clr_in, // Underrun clear
  input wire logic rcv_overrun_clr_in, // Overrun clear
  input wire logic serial_clk_out, // Bit clock
  input wire logic frame_sync_out, // Frame sync
  input wire logic xmit_hold_empty_out, // Tx empty
  input wire logic xmit_underrun_flag_out, // Underrun
  input wire logic rcv_hold_full_out, // Rx full
  input wire logic rcv_overrun_flag_out, // Overrun
  input wire logic xmit_frame_slot_out, // Frame slot
  input wire logic xmit_irq_out, // Tx request
  input wire logic rcv_irq_out // Rx request
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [DIV_W-1:0] run_r;
  logic [DIV_W-1:0] half;
  logic last_r;
  logic seen_r;
  assign half = ({4'h0, prescale_modulus_field_in} + 12'h001) << (prescaler_range_bit_in ? RANGE_SHIFT : 0);
  // Frozen with ce_in, like the divider itself
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_r <= '0;
      last_r <= 1'b0;
      seen_r <= 1'b0;
    end else if (ce_in) begin
      run_r <= (serial_clk_out != last_r) ? 12'h001 : run_r + 12'h001;
      seen_r <= seen_r | (serial_clk_out != last_r);
      last_r <= serial_clk_out;
    end
  end
  sequence s_hold_wr;
    ce_in && xmit_hold_wr_in;
  endsequence
  sequence s_skip_wr;
    ce_in && slot_skip_wr_in;
  endsequence
  a_write_clears_empty: assert property (s_hold_wr |=> !xmit_hold_empty_out)
    else $error("empty flag still set after a data write");
  a_skip_clears_empty: assert property (s_skip_wr |=> !xmit_hold_empty_out)
    else $error("empty flag still set after a skip write");
  a_xmit_irq_cause: assert property (xmit_irq_out |-> $past(xmit_irq_on_in) && $past(xmit_hold_empty_out))
    else $error("transmit request without enable and empty");
  a_rcv_irq_lag: assert property (ce_in && $past(ce_in) |->
    rcv_irq_out == ($past(rcv_irq_on_in) && $past(rcv_hold_full_out)))
    else $error("receive request does not follow full flag");
  a_underrun_sticky: assert property ($fell(xmit_underrun_flag_out) |-> $past(xmit_underrun_clr_in))
    else $error("underrun flag dropped without a clear");
  a_overrun_sticky: assert property ($fell(rcv_overrun_flag_out) |-> $past(rcv_overrun_clr_in))
    else $error("overrun flag dropped without a clear");
  a_bit_clock_period: assert property (ce_in && seen_r && network_select_in && link_master_in
    && !gated_clock_select_in && serial_clk_out != last_r |-> run_r == half)
    else $error("bit clock half period differs from divider setting");
  a_frame_slot_sync: assert property ($rose(xmit_frame_slot_out) && link_master_in |-> ##[0:2] frame_sync_out)
    else $error("frame slot started without frame sync");
endmodule : tdm_network_chk

bind tdm_network_serial_port tdm_network_chk u_chk (.*);

// ==== verif/tdm_link_partner.sv ====
// Far side of the TDM data line: a loop-back that returns the block's own transmit pin.
// Assumes the block is bit clock master; the line is looped back to it.
module tdm_link_partner (
  input wire logic clk_in, // System clock
  input wire logic line_in, // Block transmit pin
  input wire logic drive_in, // Block drive enable
  output logic serial_in_out // Line level to the block
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last_r = 1'b0;
  always @(posedge clk_in) begin
    last_r <= serial_in_out;
  end
  // Released line has no pull: toggle rather than keep the old bit
  assign serial_in_out = (drive_in === 1'b1) ? line_in : ~last_r;
endmodule : tdm_link_partner

// ==== verif/testbench.sv ====
// Self-checking bench for the TDM network port as bit clock master.
// Assumes the loop-back partner on the data line and the bound checker.
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module testbench
  import tdm_network_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SLOT = 64; // Eight bits, half bit of four cycles
  localparam int LIMIT = 3000;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic network_select_in = 1'b1;
  logic link_master_in = 1'b1;
  logic [1:0] word_length_field_in = WL_SEL_8;
  logic [4:0] slots_per_frame_field_in = 5'h03;
  logic prescaler_range_bit_in = 1'b0;
  logic [7:0] prescale_modulus_field_in = 8'h03;
  logic gated_clock_select_in = 1'b0;
  logic shared_clock_select_in = 1'b1;
  logic [1:0] frame_pulse_length_bits_in = 2'h0;
  logic xmit_on_bit_in = 1'b0, rcv_on_bit_in = 1'b0, xmit_irq_on_in = 1'b0, rcv_irq_on_in = 1'b0;
  logic [1:0] output_flag_bits_in = 2'h1;
  logic xmit_hold_wr_in = 1'b0, slot_skip_wr_in = 1'b0, rcv_hold_rd_in = 1'b0;
  logic xmit_underrun_clr_in = 1'b0, rcv_overrun_clr_in = 1'b0;
  logic [DATA_W-1:0] xmit_hold_data_in = WORD_RST;
  logic serial_clk_in, frame_sync_in, serial_in_pin_in;
  logic serial_clk_out, frame_sync_out, serial_out_pin_out, serial_out_oe_out;
  logic [1:0] output_flag_out;
  logic xmit_hold_empty_out, xmit_underrun_flag_out, rcv_hold_full_out, rcv_overrun_flag_out;
  logic [DATA_W-1:0] rcv_hold_out;
  logic xmit_frame_slot_out, rcv_frame_slot_out, xmit_irq_out, rcv_irq_out;
  int fail_count = 0, n_checks = 0, cycles = 0, i;
  // Slave inputs follow the master outputs, reading 0 whenever those are not 1
  assign serial_clk_in = (serial_clk_out === 1'b1);
  assign frame_sync_in = (frame_sync_out === 1'b1);
  tdm_link_partner u_far (
    .clk_in(clk_in),
    .line_in(serial_out_pin_out),
    .drive_in(serial_out_oe_out),
    .serial_in_out(serial_in_pin_in)
  );
  tdm_network_serial_port DUT (.*);
  always #5 clk_in = ~clk_in;
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      print_verdict();
    end
  end
  // One software service per slot: strobes at the edge after the boundary
  task automatic slot(input logic wr, sk, input logic [7:0] d, input logic rd, clr, ton, input logic [1:0] f);
    @(posedge clk_in);
    xmit_hold_wr_in <= wr;
    slot_skip_wr_in <= sk;
    xmit_hold_data_in <= {16'h0000, d};
    rcv_hold_rd_in <= rd;
    xmit_underrun_clr_in <= clr;
    rcv_overrun_clr_in <= clr;
    xmit_on_bit_in <= ton;
    output_flag_bits_in <= f;
    @(posedge clk_in);
    {xmit_hold_wr_in, slot_skip_wr_in, rcv_hold_rd_in, xmit_underrun_clr_in, rcv_overrun_clr_in} <= 5'h00;
    repeat (SLOT - 2) @(posedge clk_in);
    #1;
  endtask : slot
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    `CHK({xmit_hold_empty_out, xmit_underrun_flag_out, rcv_hold_full_out, serial_out_oe_out}, 4'h8)
    slot(1, 0, 8'ha5, 0, 0, 0, 2'h1);
    `CHK(xmit_hold_empty_out, 1'b0)
    @(posedge clk_in);
    {rcv_on_bit_in, rcv_irq_on_in, xmit_on_bit_in, xmit_irq_on_in} <= 4'hf;
    i = 0;
    while (xmit_hold_empty_out !== 1'b1 && i < 600) begin
      @(posedge clk_in);
      #1;
      i++;
    end
    `CHK({xmit_frame_slot_out, frame_sync_out, serial_out_oe_out, serial_out_pin_out}, 4'hf)
    `CHK({rcv_hold_full_out, output_flag_out}, 3'h1)
    slot(0, 1, 8'h00, 0, 0, 1, 2'h2);
    `CHK({serial_out_oe_out, frame_sync_out, xmit_underrun_flag_out, output_flag_out}, 5'h02)
    `CHK({rcv_hold_full_out, rcv_frame_slot_out, rcv_hold_out}, {2'h3, 24'h00_00a5})
    slot(1, 0, 8'h3c, 1, 0, 1, 2'h1);
    `CHK({serial_out_oe_out, rcv_hold_full_out, xmit_frame_slot_out, output_flag_out}, 5'h19)
    slot(1, 0, 8'h96, 1, 0, 1, 2'h1);
    `CHK({rcv_hold_full_out, rcv_frame_slot_out, rcv_hold_out}, {2'h2, 24'h00_003c})
    `CHK({serial_out_oe_out, xmit_underrun_flag_out}, 2'h2)
    slot(0, 0, 8'h00, 0, 0, 1, 2'h1);
    `CHK({xmit_underrun_flag_out, serial_out_pin_out, xmit_frame_slot_out, xmit_hold_empty_out}, 4'hf)
    `CHK({rcv_overrun_flag_out, rcv_hold_out}, {1'b1, 24'h00_003c})
    slot(0, 0, 8'h00, 1, 1, 0, 2'h1);
    `CHK({rcv_hold_out, rcv_frame_slot_out}, {24'h00_0096, 1'b1})
    `CHK({serial_out_oe_out, xmit_underrun_flag_out, rcv_overrun_flag_out}, 3'h0)
    @(posedge clk_in);
    rcv_on_bit_in <= 1'b0;
    ce_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    ce_in <= 1'b1;
    shared_clock_select_in <= 1'b0;
    frame_pulse_length_bits_in <= 2'h1;
    repeat (3 * SLOT) @(posedge clk_in);
    {network_select_in, gated_clock_select_in} <= 2'h1;
    repeat (20) @(posedge clk_in);
    #1;
    `CHK(serial_out_oe_out, 1'b0)
    @(posedge clk_in);
    {word_length_field_in, slots_per_frame_field_in, prescaler_range_bit_in} <= {WL_SEL_16, 5'h01, 1'b1};
    {prescale_modulus_field_in, gated_clock_select_in} <= {8'h00, 1'b0};
    {rcv_on_bit_in, xmit_on_bit_in, rcv_hold_rd_in, rcv_overrun_clr_in, xmit_hold_wr_in} <= 5'h1f;
    xmit_hold_data_in <= 24'h00_c3a5;
    @(posedge clk_in);
    {rcv_hold_rd_in, rcv_overrun_clr_in, xmit_hold_wr_in} <= 3'h0;
    // Let the divider settle before the port runs again
    repeat (40) @(posedge clk_in);
    network_select_in <= 1'b1;
    i = 0;
    while (rcv_hold_full_out !== 1'b1 && i < 600) begin
      @(posedge clk_in);
      #1;
      i++;
    end
    `CHK({rcv_hold_full_out, rcv_frame_slot_out, xmit_underrun_flag_out, rcv_hold_out}, {3'h7, 24'h00_c3a5})
    print_verdict();
  end
endmodule : testbench
